// *** pkg/sstc_pkg.sv ***
// sstc_pkg: constants for the sensor self-test control block
package sstc_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0]  CFG5_ADDR       = 8'h44;
    localparam logic [7:0]  CFG5_RESET      = 8'h00;
    localparam int          SEL_MSB         = 7;
    localparam int          SEL_LSB         = 4;
    localparam logic [7:0]  CFG5_ARRAY_MASK = 8'h0F;
    localparam int          DATA_W          = 16;
    localparam logic [15:0] RESULT_RESET    = 16'h0000;

    // ****************************************************************
    // self-test select codes
    // ****************************************************************
    localparam logic [3:0] SEL_NORMAL  = 4'h0;
    localparam logic [3:0] SEL_CMV     = 4'h1;
    localparam logic [1:0] GRP_INHIBIT = 2'h1;
    localparam logic [1:0] GRP_DIGITAL = 2'h3;

    // ****************************************************************
    // forced patterns and signatures, indexed by select[1:0]
    // ****************************************************************
    localparam logic [15:0] PAT_0 = 16'h0000;
    localparam logic [15:0] PAT_1 = 16'hAAAA;
    localparam logic [15:0] PAT_2 = 16'h5555;
    localparam logic [15:0] PAT_3 = 16'hFFFF;
    localparam logic [15:0] SIG_0 = 16'h8171;
    localparam logic [15:0] SIG_1 = 16'h6C95;
    localparam logic [15:0] SIG_2 = 16'h807A;
    localparam logic [15:0] SIG_3 = 16'h78AC;

    typedef enum {
        SSTC_NORMAL,
        SSTC_CMV,
        SSTC_INHIBIT,
        SSTC_DIGITAL
    } sstc_mode_e;
endpackage : sstc_pkg

// *** hw/sstc_result_reg.sv ***
// sstc_result_reg: registered sensor result holder
`timescale 1ns/10ps
module sstc_result_reg (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        wr_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o
);
    logic [15:0] data_d;
    logic [15:0] data_q;

    always_comb begin
        data_d = wr_i ? wdata_i : data_q;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_q <= sstc_pkg::RESULT_RESET;
        end else begin
            data_q <= data_d;
        end
    end

    assign rdata_o = data_q;
endmodule : sstc_result_reg

// *** hw/sstc_top.sv ***
// sstc_top: self-test select register and result override
`timescale 1ns/10ps
module sstc_top (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    output logic      [7:0]  array_bits_o,
    input  wire logic        dsp_wr_i,
    input  wire logic [15:0] dsp_data_i,
    output logic      [15:0] sensor_result_regs_o,
    output logic      [3:0]  self_test_select_o,
    output logic             cmv_en_o,
    output logic             dsp_inhibit_o
);
    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic sstc_pkg::sstc_mode_e mode_of(input logic [3:0] s);
        if (s[3:2] == sstc_pkg::GRP_DIGITAL) begin
            return sstc_pkg::SSTC_DIGITAL;
        end else if (s[3:2] == sstc_pkg::GRP_INHIBIT) begin
            return sstc_pkg::SSTC_INHIBIT;
        end else if (s == sstc_pkg::SEL_CMV) begin
            return sstc_pkg::SSTC_CMV;
        end else begin
            return sstc_pkg::SSTC_NORMAL;
        end
    endfunction : mode_of

    function automatic logic [15:0] forced_of(input logic [3:0] s);
        logic [15:0] v;
        v = sstc_pkg::PAT_0;
        if (s[3:2] == sstc_pkg::GRP_DIGITAL) begin
            case (s[1:0])
                2'h0:    v = sstc_pkg::SIG_0;
                2'h1:    v = sstc_pkg::SIG_1;
                2'h2:    v = sstc_pkg::SIG_2;
                default: v = sstc_pkg::SIG_3;
            endcase
        end else begin
            case (s[1:0])
                2'h0:    v = sstc_pkg::PAT_0;
                2'h1:    v = sstc_pkg::PAT_1;
                2'h2:    v = sstc_pkg::PAT_2;
                default: v = sstc_pkg::PAT_3;
            endcase
        end
        return v;
    endfunction : forced_of

    // ****************************************************************
    // configuration register
    // ****************************************************************
    logic [7:0]  cfg_d;
    logic [7:0]  cfg_q;
    logic [7:0]  rdata_d;
    logic [7:0]  rdata_q;
    logic [7:0]  arr_d;
    logic [7:0]  arr_q;
    logic        hit;
    logic [3:0]  sel;

    assign hit = (reg_addr_i == sstc_pkg::CFG5_ADDR);
    assign sel = cfg_q[sstc_pkg::SEL_MSB:sstc_pkg::SEL_LSB];

    always_comb begin
        cfg_d = cfg_q;
        if (reg_wr_i && hit) begin
            cfg_d = reg_wdata_i;
        end
        rdata_d = hit ? cfg_d : 8'h00;
        // select bits masked so mode changes never upset the array check
        arr_d = cfg_d & sstc_pkg::CFG5_ARRAY_MASK;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_q   <= sstc_pkg::CFG5_RESET;
            rdata_q <= sstc_pkg::CFG5_RESET;
            arr_q   <= sstc_pkg::CFG5_RESET;
        end else begin
            cfg_q   <= cfg_d;
            rdata_q <= rdata_d;
            arr_q   <= arr_d;
        end
    end

    // ****************************************************************
    // mode and result override
    // ****************************************************************
    sstc_pkg::sstc_mode_e mode_d;
    sstc_pkg::sstc_mode_e mode_q;
    logic [3:0]  sel_q;
    logic        cmv_d;
    logic        cmv_q;
    logic        inh_d;
    logic        inh_q;
    logic        res_wr;
    logic [15:0] res_wdata;
    logic [15:0] res_q;

    always_comb begin
        // only the select nibble decides the mode, never the array bits
        mode_d    = mode_of(cfg_d[sstc_pkg::SEL_MSB:sstc_pkg::SEL_LSB]);
        cmv_d     = (mode_d == sstc_pkg::SSTC_CMV);
        inh_d     = (mode_d == sstc_pkg::SSTC_INHIBIT);
        res_wr    = 1'b0;
        res_wdata = dsp_data_i;
        case (mode_q)
            sstc_pkg::SSTC_INHIBIT,
            sstc_pkg::SSTC_DIGITAL: begin
                // dsp writes ignored while a pattern is forced
                res_wr    = 1'b1;
                res_wdata = forced_of(sel);
            end
            sstc_pkg::SSTC_NORMAL,
            sstc_pkg::SSTC_CMV: begin
                res_wr = dsp_wr_i;
            end
            default: begin
                res_wr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_q <= sstc_pkg::SSTC_NORMAL;
            sel_q  <= sstc_pkg::SEL_NORMAL;
            cmv_q  <= 1'b0;
            inh_q  <= 1'b0;
        end else begin
            mode_q <= mode_d;
            sel_q  <= cfg_d[sstc_pkg::SEL_MSB:sstc_pkg::SEL_LSB];
            cmv_q  <= cmv_d;
            inh_q  <= inh_d;
        end
    end

    sstc_result_reg u_result (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .wr_i    (res_wr),
        .wdata_i (res_wdata),
        .rdata_o (res_q)
    );

    assign reg_rdata_o          = rdata_q;
    assign array_bits_o         = arr_q;
    assign sensor_result_regs_o = res_q;
    assign self_test_select_o   = sel_q;
    assign cmv_en_o             = cmv_q;
    assign dsp_inhibit_o        = inh_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_RESET_ZERO: assert property (@(posedge clk_i)
        $rose(rstn_i) |-> cfg_q == 8'h00)
        else $error("config not zero after reset");
    AST_ARRAY_MASK: assert property (@(posedge clk_i) disable iff (!rstn_i)
        array_bits_o[7:4] == 4'h0)
        else $error("select bits leaked into array check");
    AST_CMV: assert property (@(posedge clk_i) disable iff (!rstn_i)
        cmv_en_o == (self_test_select_o == 4'h1))
        else $error("common-mode verify enable wrong");
    AST_INHIBIT_PAT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (sel == 4'h5 && sel_q == 4'h5) |=> sensor_result_regs_o == 16'hAAAA)
        else $error("pattern AAAA not forced");
    AST_ZERO_PAT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (sel == 4'h4 && sel_q == 4'h4) |=> sensor_result_regs_o == 16'h0000)
        else $error("pattern 0000 not forced");
    AST_PAT_55: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (sel == 4'h6 && sel_q == 4'h6) |=> sensor_result_regs_o == 16'h5555)
        else $error("pattern 5555 not forced");
    AST_PAT_FF: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (sel == 4'h7 && sel_q == 4'h7) ##1 dsp_wr_i
        |=> sensor_result_regs_o == 16'hFFFF)
        else $error("dsp write not inhibited");
    AST_SIG_0: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (sel == 4'hC && sel_q == 4'hC) |=> sensor_result_regs_o == 16'h8171)
        else $error("self-test 0 signature wrong");
    AST_SIG_3: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (sel == 4'hF && sel_q == 4'hF) |=> sensor_result_regs_o == 16'h78AC)
        else $error("self-test 3 signature wrong");
    AST_RW: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (reg_wr_i && reg_addr_i == 8'h44) |=> reg_rdata_o == $past(reg_wdata_i)
        || reg_addr_i != 8'h44)
        else $error("config readback wrong");
    AST_NORMAL_PASS: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (mode_q == sstc_pkg::SSTC_NORMAL && dsp_wr_i)
        |=> sensor_result_regs_o == $past(dsp_data_i))
        else $error("dsp write lost in normal mode");
endmodule : sstc_top

// *** tb/sstc_host_model.sv ***
// sstc_host_model: host side of the config register port
`timescale 1ns/10ps
module sstc_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic            wr_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    // ****
    // register cycles, one byte each
    // ****
    initial begin
        wr_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // single-cycle strobe; callers keep to legal select codes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask : wr
    // read data lands one edge after the address is seen
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask : rd
endmodule : sstc_host_model

// *** tb/sstc_top_test.sv ***
// sstc_top_test: self-checking bench for the self-test select block
`timescale 1ns/10ps
module sstc_top_test;
    // ****
    // stimulus and checking
    // ****
    logic clk_i = 1'b0;
    logic rstn_i, reg_wr_i, dsp_wr_i, cmv_en_o, dsp_inhibit_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, array_bits_o, v, rd;
    logic [15:0] dsp_data_i, sensor_result_regs_o, d;
    logic [3:0] self_test_select_o;
    int fails = 0, n_tests = 0, cyc = 0;
    int unsigned seed = 37989;
    int codes[10] = '{0, 1, 4, 5, 6, 7, 12, 13, 14, 15};
    // -1 marks codes where the DSP value passes through
    int pats[16] = '{-1, -1, -1, -1, 16'h0000, 16'hAAAA, 16'h5555,
        16'hFFFF, -1, -1, -1, -1, 16'h8171, 16'h6C95, 16'h807A, 16'h78AC};

    always #12.5 clk_i = ~clk_i;

    sstc_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .array_bits_o(array_bits_o),
        .dsp_wr_i(dsp_wr_i), .dsp_data_i(dsp_data_i),
        .sensor_result_regs_o(sensor_result_regs_o),
        .self_test_select_o(self_test_select_o),
        .cmv_en_o(cmv_en_o), .dsp_inhibit_o(dsp_inhibit_o));
    sstc_host_model host (.clk_i(clk_i), .rdata_i(reg_rdata_o),
        .wr_o(reg_wr_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));

    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    // hang guard, well above the 86 or so cycles needed
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        rstn_i = 1'b0;
        dsp_wr_i = 1'b0;
        dsp_data_i = 16'h0000;
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        host.rd(sstc_pkg::CFG5_ADDR, rd);
        chk({8'h00, rd}, 16'h0000);
        chk({12'h000, self_test_select_o}, 16'h0000);
        $display("test reset done");
        foreach (codes[i]) begin
            v = {4'(codes[i]), 4'(rnd())};
            host.wr(sstc_pkg::CFG5_ADDR, v);
            host.rd(sstc_pkg::CFG5_ADDR, rd);
            chk({8'h00, rd}, {8'h00, v});
            chk({12'h000, self_test_select_o}, 16'(codes[i]));
            chk({15'h0000, cmv_en_o}, 16'(codes[i] == 1));
            chk({15'h0000, dsp_inhibit_o}, 16'(codes[i] inside {[4:7]}));
            chk({8'h00, array_bits_o}, {12'h000, v[3:0]});
            // DSP write tried in every mode; forced ones must ignore it
            d = 16'(rnd());
            @(posedge clk_i);
            dsp_wr_i <= 1'b1;
            dsp_data_i <= d;
            @(posedge clk_i);
            dsp_wr_i <= 1'b0;
            @(posedge clk_i);
            #1;
            chk(sensor_result_regs_o,
                pats[codes[i]] < 0 ? d : 16'(pats[codes[i]]));
        end
        $display("test select codes done");
        host.wr(8'h45, 8'h50);
        host.rd(8'h45, rd);
        chk({8'h00, rd}, 16'h0000);
        chk({12'h000, self_test_select_o}, 16'h000F);
        $display("test unmapped done");
        close_out();
    end
endmodule : sstc_top_test
